/* core/rsel_event_logic.sv */
// Top of the room sensor event logic: light, motion, reed and external input
`timescale 1ns/100ps
// Notes on behaviour
// - Light threshold accepted within 1 to 63
// - Dark above threshold goes bright, event
// - Bright below threshold goes dark, event
// - Light event reporting can be disabled
// - Light intensity reported periodically, independently
// - Motion reported only at first detection
// - Grace timer expiry reports motion ended
// - Edge select: close, open or both
// - Report count: zero none, n after n
// - Switch function enabled by reed_function_en
// - External input digital or analog mode
// - Digital mode has own independent counter
// - Analog mode reports voltage in millivolts
module rsel_event_logic
    import rsel_pkg::*;
#(
    parameter int LIGHT_W = RSEL_LIGHT_W,
    parameter int COUNT_W = RSEL_COUNT_W,
    parameter int GRACE_W = RSEL_GRACE_W,
    parameter int MV_W = RSEL_MV_W
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [LIGHT_W-1:0] light_threshold,
    input wire logic light_event_en,
    input wire logic light_sample_valid,
    input wire logic [LIGHT_W-1:0] light_sample,
    input wire logic light_period_tick,
    output logic light_bright,
    output logic light_event,
    output logic light_periodic_report,
    output logic [LIGHT_W-1:0] light_intensity,
    input wire logic motion_enable,
    input wire logic infrared_motion_detector,
    input wire logic [GRACE_W-1:0] grace_period,
    input wire logic grace_tick,
    output logic motion_start_report,
    output logic motion_end_report,
    output logic motion_active,
    input wire logic reed_closed,
    input wire logic reed_function_en,
    input wire logic [1:0] reed_edge_sel,
    input wire logic [COUNT_W-1:0] reed_report_count,
    output logic reed_report,
    output logic [COUNT_W-1:0] reed_event_count,
    input wire logic ext_analog_mode,
    input wire logic ext_line_in,
    input wire logic [1:0] ext_edge_sel,
    input wire logic [COUNT_W-1:0] ext_report_count,
    output logic ext_report,
    output logic [COUNT_W-1:0] ext_event_count,
    input wire logic ext_mv_valid,
    input wire logic [MV_W-1:0] ext_mv_sample,
    output logic ext_voltage_report,
    output logic [MV_W-1:0] ext_voltage_mv
);
    // Light status
    logic bright_r;
    logic bright_nxt;
    logic light_init_r;
    logic light_event_r;
    logic periodic_r;
    logic [LIGHT_W-1:0] intensity_r;

    // Strictly above; a sample equal to the threshold never moves the status
    function automatic logic above_thr(input logic [LIGHT_W-1:0] level, input logic [LIGHT_W-1:0] thr);
        return level > thr;
    endfunction : above_thr

    wire thr_valid = (light_threshold >= LIGHT_W'(RSEL_THR_MIN)) &&
                     (light_threshold <= LIGHT_W'(RSEL_THR_MAX));
    wire go_bright = !bright_r && above_thr(light_sample, light_threshold);
    wire go_dark = bright_r && (light_sample < light_threshold);
    wire light_change = light_sample_valid && thr_valid && light_init_r && (go_bright || go_dark);
    wire first_sample = light_sample_valid && thr_valid && !light_init_r;
    wire light_event_nxt = light_change && light_event_en;

    assign bright_nxt = first_sample ? above_thr(light_sample, light_threshold) :
                        (light_change ? !bright_r : bright_r);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bright_r <= 1'b0;
            light_init_r <= 1'b0;
            light_event_r <= 1'b0;
        end else begin
            bright_r <= bright_nxt;
            light_init_r <= light_init_r | first_sample;
            light_event_r <= light_event_nxt;
        end
    end

    // Periodic intensity report, independent of the event path
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            intensity_r <= LIGHT_W'(RSEL_LIGHT_ZERO);
            periodic_r <= 1'b0;
        end else begin
            if (light_sample_valid) begin
                intensity_r <= light_sample;
            end
            periodic_r <= light_period_tick;
        end
    end

    assign light_bright = bright_r;
    assign light_event = light_event_r;
    assign light_periodic_report = periodic_r;
    assign light_intensity = intensity_r;

    // Motion with grace period
    rsel_motion_e mot_r;
    rsel_motion_e mot_nxt;
    logic [GRACE_W-1:0] grace_r;
    logic [GRACE_W-1:0] grace_nxt;
    logic start_r;
    logic end_r;

    wire detect = motion_enable && infrared_motion_detector;
    wire grace_done = (grace_r == '0) || (grace_r == GRACE_W'(1) && grace_tick);
    wire start_now = (mot_r == RSEL_MOT_IDLE) && detect;
    wire end_now = (mot_r == RSEL_MOT_ACTIVE) && !detect && grace_done;

    always_comb begin
        mot_nxt = mot_r;
        grace_nxt = grace_r;
        unique case (mot_r)
            RSEL_MOT_IDLE: begin
                if (detect) begin
                    mot_nxt = RSEL_MOT_ACTIVE;
                    grace_nxt = grace_period;
                end
            end
            RSEL_MOT_ACTIVE: begin
                if (detect) begin
                    grace_nxt = grace_period;
                end else if (grace_done) begin
                    mot_nxt = RSEL_MOT_IDLE;
                    grace_nxt = GRACE_W'(RSEL_GRACE_ZERO);
                end else if (grace_tick) begin
                    grace_nxt = grace_r - GRACE_W'(1);
                end
            end
            default: begin
                mot_nxt = RSEL_MOT_IDLE;
                grace_nxt = GRACE_W'(RSEL_GRACE_ZERO);
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mot_r <= RSEL_MOT_IDLE;
            grace_r <= GRACE_W'(RSEL_GRACE_ZERO);
            start_r <= 1'b0;
            end_r <= 1'b0;
        end else begin
            mot_r <= mot_nxt;
            grace_r <= grace_nxt;
            start_r <= start_now;
            end_r <= end_now;
        end
    end

    assign motion_start_report = start_r;
    assign motion_end_report = end_r;
    assign motion_active = (mot_r == RSEL_MOT_ACTIVE);

    // Reed switch and external digital input, one counter each
    rsel_switch_counter #(.COUNT_W(COUNT_W)) u_reed (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .enable(reed_function_en),
        .sw_closed(reed_closed),
        .edge_sel(reed_edge_sel),
        .report_count(reed_report_count),
        .sw_report(reed_report),
        .event_count(reed_event_count)
    );

    // Line low means closed: open-drain source pulls it down
    wire ext_closed = !ext_line_in;
    rsel_switch_counter #(.COUNT_W(COUNT_W)) u_ext (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .enable(!ext_analog_mode),
        .sw_closed(ext_closed),
        .edge_sel(ext_edge_sel),
        .report_count(ext_report_count),
        .sw_report(ext_report),
        .event_count(ext_event_count)
    );

    // Analog mode voltage report
    logic mv_rep_r;
    logic [MV_W-1:0] mv_r;
    wire mv_take = ext_analog_mode && ext_mv_valid;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mv_rep_r <= 1'b0;
            mv_r <= MV_W'(RSEL_MV_ZERO);
        end else begin
            mv_rep_r <= mv_take;
            if (mv_take) begin
                mv_r <= ext_mv_sample;
            end
        end
    end

    assign ext_voltage_report = mv_rep_r;
    assign ext_voltage_mv = mv_r;

    // Light path checks
    a_light_event_edge: assert property (@(posedge ref_clk) disable iff (!reset_n)
        light_event_r |-> (bright_r != $past(bright_r)))
        else $error("light event without change");
    a_light_disable: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !$past(light_event_en) |-> !light_event_r)
        else $error("light event while disabled");
    a_dark_transition: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (light_sample_valid && thr_valid && light_init_r && bright_r && light_sample < light_threshold)
        |=> !bright_r)
        else $error("missed dark transition");
    a_first_silent: assert property (@(posedge ref_clk) disable iff (!reset_n)
        first_sample |=> !light_event_r)
        else $error("event on first sample");
    a_bad_thr: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !thr_valid |=> $stable(bright_r))
        else $error("status moved on bad threshold");
    a_bright_rise: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (light_sample_valid && thr_valid && light_init_r && !bright_r && light_sample > light_threshold)
        |=> (light_bright && light_event == $past(light_event_en)))
        else $error("missed bright transition");
    a_dark_event: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (light_sample_valid && thr_valid && light_init_r && bright_r && light_sample < light_threshold)
        |=> (light_event == $past(light_event_en)))
        else $error("dark event not as enabled");
    a_equal_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (light_sample_valid && light_init_r && light_sample == light_threshold) |=> $stable(light_bright))
        else $error("status moved at threshold");
    a_first_status: assert property (@(posedge ref_clk) disable iff (!reset_n)
        first_sample |=> (light_bright == $past(light_sample > light_threshold)))
        else $error("first sample status wrong");
    a_idle_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !light_sample_valid |=> $stable(light_bright))
        else $error("status moved without sample");
    a_intensity_kept: assert property (@(posedge ref_clk) disable iff (!reset_n)
        light_sample_valid |=> (light_intensity == $past(light_sample)))
        else $error("intensity not stored");
    a_periodic: assert property (@(posedge ref_clk) disable iff (!reset_n)
        light_period_tick |=> light_periodic_report)
        else $error("periodic report missed");
    a_periodic_only: assert property (@(posedge ref_clk) disable iff (!reset_n)
        light_periodic_report |-> $past(light_period_tick))
        else $error("unrequested periodic report");

    // Motion checks
    a_motion_once: assert property (@(posedge ref_clk) disable iff (!reset_n)
        start_r |-> !$past(start_r))
        else $error("repeated motion start");
    a_motion_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!motion_active && detect) |=> (motion_start_report && motion_active))
        else $error("missed motion start");
    a_motion_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (motion_active && detect) |=> (motion_active && !motion_start_report && !motion_end_report))
        else $error("report while motion continues");
    a_grace_reload: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (motion_active && detect) |=> (grace_r == $past(grace_period)))
        else $error("grace not reloaded");
    a_grace_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (motion_active && !detect && !grace_done && grace_tick) |=> (grace_r == $past(grace_r) - GRACE_W'(1)))
        else $error("grace not counted down");
    a_motion_end: assert property (@(posedge ref_clk) disable iff (!reset_n)
        end_r |-> ($past(mot_r) == RSEL_MOT_ACTIVE && !$past(detect)))
        else $error("bad motion end");
    a_end_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
        motion_end_report |-> (!motion_active && !motion_start_report))
        else $error("motion end while still active");

    // Switch and external input checks
    a_reed_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !reed_function_en |=> $stable(reed_event_count))
        else $error("reed counted while disabled");
    a_reed_cleared: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reed_report |-> (reed_event_count == '0))
        else $error("reed count kept after report");
    a_ext_cleared: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ext_report |-> (ext_event_count == '0))
        else $error("external count kept after report");
    a_analog_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ext_analog_mode [*2] |-> !ext_report)
        else $error("digital report in analog mode");
    a_analog_frozen: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ext_analog_mode |=> $stable(ext_event_count))
        else $error("external counted in analog mode");
    a_voltage_take: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ext_analog_mode && ext_mv_valid) |=> (ext_voltage_report && ext_voltage_mv == $past(ext_mv_sample)))
        else $error("voltage not reported");
    a_voltage_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ext_voltage_report |-> $past(ext_analog_mode))
        else $error("voltage report in digital mode");
    c_motion_cycle: cover property (@(posedge ref_clk) disable iff (!reset_n)
        start_r ##[1:200] end_r);
    c_light_event: cover property (@(posedge ref_clk) disable iff (!reset_n) light_event_r);
    c_reed_report: cover property (@(posedge ref_clk) disable iff (!reset_n) reed_report);
    c_mv_report: cover property (@(posedge ref_clk) disable iff (!reset_n) ext_voltage_report);
endmodule : rsel_event_logic

/* include/rsel_pkg.sv */
// Package for the room sensor event logic: widths, encodings, reset values
package rsel_pkg;
    localparam int RSEL_LIGHT_W = 6;
    localparam logic [5:0] RSEL_THR_MIN = 6'h01;
    localparam logic [5:0] RSEL_THR_MAX = 6'h3F;
    localparam int RSEL_COUNT_W = 16;
    localparam int RSEL_GRACE_W = 16;
    localparam int RSEL_MV_W = 12;
    localparam logic [15:0] RSEL_CNT_ZERO = 16'h0000;
    localparam logic [15:0] RSEL_CNT_ONE = 16'h0001;
    localparam logic [15:0] RSEL_GRACE_ZERO = 16'h0000;
    localparam logic [11:0] RSEL_MV_ZERO = 12'h000;
    localparam logic [5:0] RSEL_LIGHT_ZERO = 6'h00;
    // Edge selection codes
    localparam logic [1:0] RSEL_EDGE_CLOSE = 2'h0;
    localparam logic [1:0] RSEL_EDGE_OPEN = 2'h1;
    localparam logic [1:0] RSEL_EDGE_BOTH = 2'h2;
    typedef enum logic [1:0] {RSEL_MOT_IDLE, RSEL_MOT_ACTIVE} rsel_motion_e;
endpackage : rsel_pkg

/* core/rsel_switch_counter.sv */
// Edge selection and report counting for one switch input
`timescale 1ns/100ps
module rsel_switch_counter
    import rsel_pkg::*;
#(
    parameter int COUNT_W = RSEL_COUNT_W
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic sw_closed,
    input wire logic [1:0] edge_sel,
    input wire logic [COUNT_W-1:0] report_count,
    output logic sw_report,
    output logic [COUNT_W-1:0] event_count
);
    logic prev_r;
    logic primed_r;
    logic [COUNT_W-1:0] cnt_r;
    logic [COUNT_W-1:0] cnt_nxt;
    logic report_r;

    wire rise = primed_r && enable && sw_closed && !prev_r;
    wire fall = primed_r && enable && !sw_closed && prev_r;
    wire counted = (rise && (edge_sel == RSEL_EDGE_CLOSE || edge_sel == RSEL_EDGE_BOTH)) ||
                   (fall && (edge_sel == RSEL_EDGE_OPEN || edge_sel == RSEL_EDGE_BOTH));
    wire [COUNT_W-1:0] cnt_inc = cnt_r + COUNT_W'(1);
    wire report_now = counted && (report_count != '0) && (cnt_inc >= report_count);

    assign cnt_nxt = !counted ? cnt_r : (report_now ? '0 : cnt_inc);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_r <= 1'b0;
            primed_r <= 1'b0;
            cnt_r <= '0;
            report_r <= 1'b0;
        end else begin
            prev_r <= sw_closed;
            primed_r <= 1'b1;
            cnt_r <= cnt_nxt;
            report_r <= report_now;
        end
    end

    assign sw_report = report_r;
    assign event_count = cnt_r;

    a_report_clears: assert property (@(posedge ref_clk) disable iff (!reset_n)
        report_now |=> (cnt_r == '0))
        else $error("counter not cleared after report");
    a_zero_silent: assert property (@(posedge ref_clk) disable iff (!reset_n)
        sw_report |-> ($past(report_count) != '0))
        else $error("report with zero count");
endmodule : rsel_switch_counter

/* bench/rsel_far_model.sv */
// Far-side model: reed magnet, open-drain external source, motion detector
`timescale 1ns/100ps
module rsel_far_model (
    input wire logic magnet_near,
    input wire logic ext_sink_on,
    input wire logic person_moving,
    output logic reed_closed,
    output logic ext_line_in,
    output logic infrared_motion_detector
);
    assign reed_closed = magnet_near;
    // Open-drain sink; released line rests at the pull-up level
    assign ext_line_in = ext_sink_on ? 1'b0 : 1'b1;
    assign infrared_motion_detector = person_moving;
endmodule : rsel_far_model

/* bench/tb_top.sv */
// Self-checking testbench for the room sensor event logic
`timescale 1ns/100ps
module tb_top;
    import rsel_pkg::*;
    logic ref_clk, reset_n, light_event_en, light_sample_valid, light_period_tick, motion_enable, grace_tick;
    logic reed_function_en, ext_analog_mode, ext_mv_valid, magnet_near, ext_sink_on, person_moving;
    logic [5:0] light_threshold, light_sample, light_intensity;
    logic [15:0] grace_period, reed_report_count, ext_report_count, reed_event_count, ext_event_count;
    logic [1:0] reed_edge_sel, ext_edge_sel;
    logic [11:0] ext_mv_sample, ext_voltage_mv;
    logic light_bright, light_event, light_periodic_report, motion_start_report, motion_end_report, motion_active;
    logic reed_closed, ext_line_in, infrared_motion_detector, reed_report, ext_report, ext_voltage_report;
    int n_fail = 0;
    int compares = 0;

    rsel_far_model far (.magnet_near, .ext_sink_on, .person_moving, .reed_closed, .ext_line_in,
        .infrared_motion_detector);
    rsel_event_logic dut (.ref_clk, .reset_n, .light_threshold, .light_event_en, .light_sample_valid,
        .light_sample, .light_period_tick, .light_bright, .light_event, .light_periodic_report,
        .light_intensity, .motion_enable, .infrared_motion_detector, .grace_period, .grace_tick,
        .motion_start_report, .motion_end_report, .motion_active, .reed_closed, .reed_function_en,
        .reed_edge_sel, .reed_report_count, .reed_report, .reed_event_count, .ext_analog_mode, .ext_line_in,
        .ext_edge_sel, .ext_report_count, .ext_report, .ext_event_count, .ext_mv_valid, .ext_mv_sample,
        .ext_voltage_report, .ext_voltage_mv);

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask : chk

    task lsamp(input logic [5:0] v, input logic b, input logic e);
        @(posedge ref_clk);
        light_sample <= v;
        light_sample_valid <= 1'b1;
        @(posedge ref_clk);
        light_sample_valid <= 1'b0;
        #1;
        chk(light_bright === b && light_event === e, "light status or event");
    endtask : lsamp

    task gtick;
        @(posedge ref_clk);
        grace_tick <= 1'b1;
        @(posedge ref_clk);
        grace_tick <= 1'b0;
        #1;
    endtask : gtick

    // One transition on the reed (ext=0) or external line (ext=1)
    task sw(input logic ext, input logic closed, input logic [15:0] cnt, input logic rep);
        @(posedge ref_clk);
        if (ext) ext_sink_on <= closed;
        else magnet_near <= closed;
        @(posedge ref_clk);
        #1;
        chk((ext ? ext_event_count : reed_event_count) === cnt && (ext ? ext_report : reed_report) === rep,
            "switch count or report");
    endtask : sw

    task test_light;
        lsamp(6'h1E, 1'b1, 1'b0);
        lsamp(6'h14, 1'b1, 1'b0);
        lsamp(6'h0A, 1'b0, 1'b1);
        lsamp(6'h1E, 1'b1, 1'b1);
        light_event_en <= 1'b0;
        lsamp(6'h0A, 1'b0, 1'b0);
        light_threshold <= 6'h00;
        lsamp(6'h3F, 1'b0, 1'b0);
        @(posedge ref_clk);
        light_period_tick <= 1'b1;
        @(posedge ref_clk);
        light_period_tick <= 1'b0;
        #1;
        chk(light_periodic_report === 1'b1 && light_intensity === 6'h3F, "periodic report");
        $display("test_light done");
    endtask : test_light

    task test_motion;
        @(posedge ref_clk);
        person_moving <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk(motion_start_report === 1'b1 && motion_active === 1'b1, "motion start");
        repeat (3) @(posedge ref_clk);
        #1;
        chk(motion_start_report === 1'b0, "start repeated");
        @(posedge ref_clk);
        person_moving <= 1'b0;
        gtick();
        chk(motion_end_report === 1'b0 && motion_active === 1'b1, "early end");
        gtick();
        chk(motion_end_report === 1'b1, "motion end");
        motion_enable <= 1'b0;
        person_moving <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(motion_start_report === 1'b0 && motion_active === 1'b0, "start while disabled");
        person_moving <= 1'b0;
        motion_enable <= 1'b1;
        $display("test_motion done");
    endtask : test_motion

    task test_reed;
        sw(1'b0, 1'b1, 16'h0001, 1'b0);
        sw(1'b0, 1'b0, 16'h0001, 1'b0);
        sw(1'b0, 1'b1, 16'h0000, 1'b1);
        reed_edge_sel <= RSEL_EDGE_OPEN;
        sw(1'b0, 1'b0, 16'h0001, 1'b0);
        sw(1'b0, 1'b1, 16'h0001, 1'b0);
        reed_edge_sel <= RSEL_EDGE_BOTH;
        reed_report_count <= 16'h0001;
        sw(1'b0, 1'b0, 16'h0000, 1'b1);
        reed_report_count <= 16'h0000;
        sw(1'b0, 1'b1, 16'h0001, 1'b0);
        sw(1'b0, 1'b0, 16'h0002, 1'b0);
        reed_function_en <= 1'b0;
        sw(1'b0, 1'b1, 16'h0002, 1'b0);
        reed_function_en <= 1'b1;
        reed_edge_sel <= 2'h3;
        sw(1'b0, 1'b0, 16'h0002, 1'b0);
        $display("test_reed done");
    endtask : test_reed

    task test_ext;
        sw(1'b1, 1'b1, 16'h0001, 1'b0);
        sw(1'b1, 1'b0, 16'h0002, 1'b0);
        sw(1'b1, 1'b1, 16'h0000, 1'b1);
        chk(reed_event_count === 16'h0002, "reed disturbed");
        ext_analog_mode <= 1'b1;
        sw(1'b1, 1'b0, 16'h0000, 1'b0);
        @(posedge ref_clk);
        ext_mv_sample <= 12'h4B0;
        ext_mv_valid <= 1'b1;
        @(posedge ref_clk);
        ext_mv_valid <= 1'b0;
        #1;
        chk(ext_voltage_report === 1'b1 && ext_voltage_mv === 12'h4B0, "voltage report");
        $display("test_ext done");
    endtask : test_ext

    task conclude;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    initial begin
        {reset_n, light_event_en, light_sample_valid, light_period_tick, grace_tick, ext_analog_mode} = '0;
        {ext_mv_valid, magnet_near, ext_sink_on, person_moving, light_sample, ext_mv_sample} = '0;
        {motion_enable, reed_function_en} = 2'h3;
        light_event_en = 1'b1;
        light_threshold = 6'h14;
        grace_period = 16'h0002;
        reed_edge_sel = RSEL_EDGE_CLOSE;
        ext_edge_sel = RSEL_EDGE_BOTH;
        reed_report_count = 16'h0002;
        ext_report_count = 16'h0003;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        test_light();
        test_motion();
        test_reed();
        test_ext();
        conclude();
    end

    // Tests need about 61 cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        conclude();
    end
endmodule : tb_top
